// ===== core/bcc_core.sv
// Charger phase control, safety timers, indicator, start-up and ramp
// Functional notes
// - Rail with order code k enables at step k; code 7 never enables.
// - Ramp-enabled bucks move one step per 15.625us or 31.250us.
// - Charge only when input, enable, die, thermistor, overvoltage, timer okay.
// - Below the low-battery threshold, precharge at the precharge current.
// - Precharge current field, 25mA steps to 200mA, reset 125mA.
// - Fast current field, 25mA to 200mA, then 100mA to 1500mA; reset 300mA.
// - Target voltage 4.0/4.1/4.2/4.35/4.4V, reset 4.2V.
// - Fast current until target voltage, then constant voltage taper.
// - Above recharge and below termination: done, stop, open switch, interrupt.
// - Regulation suspends termination; timers half speed or paused by bit.
// - After done, restart below recharge level or on adapter insertion.
// - Battery detection with usable adapter when enabled; else present.
// - Timer one from precharge; timeout stops, safe mode, interrupt.
// - Timer two from constant current; timeout gives safe mode, interrupt.
// - Timer disable bit keeps timeouts from stopping charge.
// - Safe mode gives 10mA; exits on recharge, removal or enable rewrite.
// - Die at regulation point reduces current and sets status bit; core only sets thermal_reg_o, ilimit_ma_o unchanged.
// - Die at 145C interrupts and powers off, no automatic power on.
// - Thermistor out of charge window pauses charger, interrupts, resumes.
// - Thermistor out of work window pauses boost, interrupts, resumes.
// - Style A: off, fault 1Hz, overvoltage 4Hz, low while charging.
// - Style B: battery off, charge 1Hz, alarm 4Hz, low; code 10 software.
// - Phase status codes 000 to 101 as listed.
`timescale 1ns/100ps
module bcc_core #(
  parameter int N_RAIL = 15,
  parameter int TICK_DIV = bcc_pkg::TICK_DIV,
  parameter int SEQ_STEP_CYC = bcc_pkg::SEQ_STEP_CYC
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // Configuration from the host side
  input wire logic cfg_wr_i,
  input wire bcc_pkg::bcc_cfg_t cfg_i,
  // Analog comparator and sensor results
  input wire bcc_pkg::bcc_sense_t sense_i,
  // Start-up ordering
  input wire logic seq_start_i,
  input wire logic [N_RAIL-1:0][2:0] seq_code_i,
  // Buck voltage targets
  input wire logic [1:0][6:0] buck_target_i,
  // Charger status and control
  output logic [2:0] phase_o,
  output logic [10:0] ilimit_ma_o,
  output logic [12:0] vtarget_mv_o,
  output logic batt_switch_open_o,
  output logic thermal_reg_o,
  output logic bat_present_o,
  output logic boost_pause_o,
  output logic power_off_o,
  output bcc_pkg::bcc_irq_t irq_o,
  // Indicator pin, open drain
  output logic led_o,
  output logic led_oe_o,
  // Rails and ramped bucks
  output logic [N_RAIL-1:0] rail_en_o,
  output logic [1:0][6:0] buck_code_o
);
  localparam int SEQ_W = $clog2(SEQ_STEP_CYC + 1);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PRE,
    ST_CC,
    ST_CV,
    ST_DONE,
    ST_SAFE
  } bcc_chg_t;

  typedef struct packed {
    bcc_pkg::bcc_cfg_t cfg;
    bcc_chg_t st;
    logic vbus_q;
    logic half;
    logic [bcc_pkg::TMR_W-1:0] tmr;
    logic off;
    logic bat_present;
    logic [1:0] tsc;
    logic [1:0] tsw;
    logic [2:0] phase;
    logic [10:0] ima;
    logic [12:0] vmv;
    logic bsw_open;
    logic treg;
    logic bpause;
    logic led_oe;
    bcc_pkg::bcc_irq_t irq;
    logic seq_on;
    logic [2:0] seq_step;
    logic [SEQ_W-1:0] seq_cnt;
    logic [N_RAIL-1:0] rail_en;
    logic [bcc_pkg::RAMP_W-1:0] ramp_cnt;
    logic [1:0][6:0] buck;
  } bcc_state_t;

  bcc_state_t s_ff;
  bcc_state_t nxt_s;
  logic tick;
  logic [3:0] blink_ph;

  // ==========================================================
  // Shared time base
  bcc_tick_gen #(
    .DIV(TICK_DIV)
  ) u_tick (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .tick_o(tick),
    .phase_o(blink_ph)
  );

  // ==========================================================
  // Helpers
  // Window check with hysteresis; bit 0 hot fault, bit 1 cold fault
  function automatic logic [1:0] bcc_win(input logic [1:0] flt,
      input logic [7:0] code, input logic [7:0] hot,
      input logic [7:0] cold, input logic [7:0] hh, input logic [7:0] ch);
    logic [8:0] hot_clr;
    logic [8:0] cold_clr;
    logic [1:0] res;
    hot_clr = {1'b0, hot} + {1'b0, hh};
    cold_clr = (ch > cold) ? 9'h000 : ({1'b0, cold} - {1'b0, ch});
    res[0] = flt[0] ? ({1'b0, code} < hot_clr) : (code < hot);
    res[1] = flt[1] ? ({1'b0, code} > cold_clr) : (code > cold);
    return res;
  endfunction

  // Fast-charge current: fine steps to the knee, coarse above it
  function automatic logic [10:0] bcc_fast_ma(input logic [4:0] c);
    logic [11:0] ma;
    if (c <= bcc_pkg::FAST_KNEE_CODE) begin
      ma = 12'(c) * 12'(bcc_pkg::STEP_FINE_MA);
    end else begin
      // Twelve bits so the top codes cannot wrap below the clamp
      ma = 12'(bcc_pkg::KNEE_MA)
        + 12'(c - bcc_pkg::FAST_KNEE_CODE) * 12'(bcc_pkg::STEP_COARSE_MA);
    end
    if (ma > 12'(bcc_pkg::FAST_MAX_MA)) begin
      ma = 12'(bcc_pkg::FAST_MAX_MA);
    end
    return ma[10:0];
  endfunction

  // Working signals of the next-state logic
  logic ins;
  logic usable;
  logic rewrite;
  logic ts_bad;
  logic ok;
  logic regul;
  logic charging;
  logic tadv;
  logic tout1;
  logic tout2;
  logic blink1;
  logic blink4;
  logic alarm;
  logic ovp;
  logic [1:0] led_sel;
  logic [bcc_pkg::RAMP_W-1:0] ramp_per;

  // ==========================================================
  // Next-state logic
  always_comb begin
    nxt_s = s_ff;
    nxt_s.irq = '0;
    if (cfg_wr_i) begin
      nxt_s.cfg = cfg_i;
    end
    // A write that sets either enable releases safe mode
    rewrite = cfg_wr_i && (cfg_i.chg_en || cfg_i.timer_en);
    nxt_s.vbus_q = sense_i.vbus_present;
    ins = sense_i.vbus_present && !s_ff.vbus_q;
    usable = sense_i.vbus_present && sense_i.vbus_above_bat
      && sense_i.src_good;

    // Battery detection holds its last result without an adapter
    if (!s_ff.cfg.bat_det_en) begin
      nxt_s.bat_present = 1'b1;
    end else if (usable) begin
      nxt_s.bat_present = sense_i.bat_det;
    end

    // Thermistor windows, both tracked at all times
    nxt_s.tsc = bcc_win(s_ff.tsc, sense_i.ts_code, s_ff.cfg.chg_hot,
      s_ff.cfg.chg_cold, s_ff.cfg.hot_hyst, s_ff.cfg.cold_hyst);
    nxt_s.tsw = bcc_win(s_ff.tsw, sense_i.ts_code, s_ff.cfg.dis_hot,
      s_ff.cfg.dis_cold, s_ff.cfg.hot_hyst, s_ff.cfg.cold_hyst);
    ts_bad = s_ff.cfg.ts_chg_en && (|s_ff.tsc);

    // Shutdown latches until reset; cooling never powers back on
    if (sense_i.die_shut && !s_ff.off) begin
      nxt_s.off = 1'b1;
      nxt_s.irq.die_shut = 1'b1;
    end

    ok = usable && s_ff.cfg.chg_en && !sense_i.die_shut && !s_ff.off
      && !ts_bad && !sense_i.bat_ovp;
    charging = (s_ff.st == ST_PRE) || (s_ff.st == ST_CC)
      || (s_ff.st == ST_CV);
    regul = sense_i.in_dpm || (charging && sense_i.die_reg);

    // Timers halve under regulation, or stop if timing is off there
    if (tick && regul) begin
      nxt_s.half = !s_ff.half;
    end
    tadv = tick && (!regul || (s_ff.cfg.timer_dpm_en && s_ff.half));
    tout1 = s_ff.cfg.timer_en && (s_ff.tmr >= bcc_pkg::bcc_tlim(
      bcc_pkg::T1_BASE_MIN, bcc_pkg::T1_STEP_MIN, s_ff.cfg.t1_sel,
      bcc_pkg::TICKS_PER_MIN));
    tout2 = s_ff.cfg.timer_en && (s_ff.tmr >= bcc_pkg::bcc_tlim(
      bcc_pkg::T2_BASE_HR, bcc_pkg::T2_STEP_HR, s_ff.cfg.t2_sel,
      60 * bcc_pkg::TICKS_PER_MIN));
    if (charging && tadv) begin
      nxt_s.tmr = s_ff.tmr + bcc_pkg::TMR_W'(1);
    end

    // Charge phase machine
    case (s_ff.st)
      ST_IDLE: begin
        if (ok) begin
          nxt_s.tmr = '0;
          nxt_s.half = 1'b0;
          if (sense_i.bat_low) begin
            nxt_s.st = ST_PRE;
          end else if (sense_i.bat_at_target) begin
            nxt_s.st = ST_CV;
          end else begin
            nxt_s.st = ST_CC;
          end
        end
      end
      ST_PRE: begin
        if (!ok) begin
          nxt_s.st = ST_IDLE;
        end else if (!sense_i.bat_low) begin
          nxt_s.st = ST_CC;
          nxt_s.tmr = '0;
        end else if (tout1) begin
          nxt_s.st = ST_SAFE;
          nxt_s.irq.safe = 1'b1;
        end
      end
      ST_CC: begin
        if (!ok) begin
          nxt_s.st = ST_IDLE;
        end else if (tout2) begin
          nxt_s.st = ST_SAFE;
          nxt_s.irq.safe = 1'b1;
        end else if (sense_i.bat_at_target) begin
          nxt_s.st = ST_CV;
        end
      end
      ST_CV: begin
        if (!ok) begin
          nxt_s.st = ST_IDLE;
        end else if (tout2) begin
          nxt_s.st = ST_SAFE;
          nxt_s.irq.safe = 1'b1;
        end else if (s_ff.cfg.term_en && !regul && sense_i.below_term
            && sense_i.bat_above_rechg) begin
          nxt_s.st = ST_DONE;
          nxt_s.irq.done = 1'b1;
        end
      end
      ST_DONE: begin
        if (ins || !sense_i.bat_above_rechg) begin
          nxt_s.st = ST_IDLE;
        end
      end
      ST_SAFE: begin
        if (sense_i.bat_above_rechg || !sense_i.vbus_present
            || rewrite) begin
          nxt_s.st = ST_IDLE;
        end
      end
      default: begin
        nxt_s.st = ST_IDLE;
      end
    endcase

    // Thermistor events: entering a fault window interrupts once
    nxt_s.irq.ts_chg = charging && s_ff.cfg.ts_chg_en
      && (|nxt_s.tsc) && !(|s_ff.tsc);
    nxt_s.irq.ts_work = sense_i.discharging && (|nxt_s.tsw)
      && !(|s_ff.tsw);
    nxt_s.bpause = sense_i.discharging && (|nxt_s.tsw);
    nxt_s.treg = charging && sense_i.die_reg;

    // Phase report, current limit and voltage target
    nxt_s.bsw_open = (nxt_s.st == ST_DONE);
    case (nxt_s.st)
      ST_PRE: begin
        nxt_s.phase = bcc_pkg::PH_PRE;
        nxt_s.ima = (s_ff.cfg.prechg_code > bcc_pkg::PRE_MAX_CODE)
          ? bcc_pkg::KNEE_MA
          : 11'(s_ff.cfg.prechg_code) * bcc_pkg::STEP_FINE_MA;
      end
      ST_CC: begin
        nxt_s.phase = bcc_pkg::PH_CC;
        nxt_s.ima = bcc_fast_ma(s_ff.cfg.fast_code);
      end
      ST_CV: begin
        nxt_s.phase = bcc_pkg::PH_CV;
        nxt_s.ima = bcc_fast_ma(s_ff.cfg.fast_code);
      end
      ST_DONE: begin
        nxt_s.phase = bcc_pkg::PH_DONE;
        nxt_s.ima = '0;
      end
      ST_SAFE: begin
        nxt_s.phase = bcc_pkg::PH_TRICKLE;
        nxt_s.ima = bcc_pkg::SAFE_MA;
      end
      default: begin
        nxt_s.phase = bcc_pkg::PH_NONE;
        nxt_s.ima = '0;
      end
    endcase
    case (s_ff.cfg.vtarget_sel)
      3'h0: nxt_s.vmv = bcc_pkg::VT_4V00;
      3'h1: nxt_s.vmv = bcc_pkg::VT_4V10;
      3'h2: nxt_s.vmv = bcc_pkg::VT_4V20;
      3'h3: nxt_s.vmv = bcc_pkg::VT_4V35;
      default: nxt_s.vmv = bcc_pkg::VT_4V40;
    endcase

    // Indicator: low quarter of each blink period pulls the pin low
    blink1 = (blink_ph[3:2] == 2'h0);
    blink4 = (blink_ph[1:0] == 2'h0);
    ovp = sense_i.in_ovp || sense_i.bat_ovp;
    alarm = (s_ff.st == ST_SAFE) || s_ff.off || ts_bad;
    led_sel = s_ff.cfg.led_sw;
    if (s_ff.cfg.led_mode == bcc_pkg::LED_STYLE_A) begin
      if (ovp) begin
        nxt_s.led_oe = blink4;
      end else if (alarm) begin
        nxt_s.led_oe = blink1;
      end else begin
        nxt_s.led_oe = charging;
      end
    end else if (s_ff.cfg.led_mode == bcc_pkg::LED_STYLE_B) begin
      if (!sense_i.vbus_present) begin
        nxt_s.led_oe = 1'b0;
      end else if (ovp || alarm) begin
        nxt_s.led_oe = blink4;
      end else if (charging) begin
        nxt_s.led_oe = blink1;
      end else begin
        nxt_s.led_oe = !s_ff.bat_present || (s_ff.st == ST_DONE);
      end
    end else if (s_ff.cfg.led_mode == bcc_pkg::LED_STYLE_SW) begin
      nxt_s.led_oe = (led_sel == bcc_pkg::LED_SW_LOW)
        || ((led_sel == bcc_pkg::LED_SW_1HZ) && blink1)
        || ((led_sel == bcc_pkg::LED_SW_4HZ) && blink4);
    end else begin
      nxt_s.led_oe = 1'b0;
    end

    // Start-up order: each step enables rails carrying that code
    if (seq_start_i) begin
      nxt_s.seq_on = 1'b1;
      nxt_s.seq_step = '0;
      nxt_s.seq_cnt = '0;
      for (int i = 0; i < N_RAIL; i++) begin
        nxt_s.rail_en[i] = (seq_code_i[i] == 3'h0);
      end
    end else if (s_ff.seq_on) begin
      if (s_ff.seq_cnt == SEQ_W'(SEQ_STEP_CYC - 1)) begin
        nxt_s.seq_cnt = '0;
        nxt_s.seq_step = s_ff.seq_step + 3'h1;
        nxt_s.seq_on = (s_ff.seq_step + 3'h1) != bcc_pkg::SEQ_LAST;
        for (int i = 0; i < N_RAIL; i++) begin
          if ((seq_code_i[i] == s_ff.seq_step + 3'h1)
              && (seq_code_i[i] != bcc_pkg::SEQ_NEVER)) begin
            nxt_s.rail_en[i] = 1'b1;
          end
        end
      end else begin
        nxt_s.seq_cnt = s_ff.seq_cnt + SEQ_W'(1);
      end
    end

    // Voltage ramp shared by both buck channels
    ramp_per = s_ff.cfg.ramp_slow
      ? bcc_pkg::RAMP_W'(bcc_pkg::RAMP_SLOW_CYC)
      : bcc_pkg::RAMP_W'(bcc_pkg::RAMP_FAST_CYC);
    if (!s_ff.cfg.ramp_en) begin
      nxt_s.ramp_cnt = '0;
      nxt_s.buck = buck_target_i;
    end else if (s_ff.ramp_cnt >= ramp_per - bcc_pkg::RAMP_W'(1)) begin
      nxt_s.ramp_cnt = '0;
      for (int b = 0; b < 2; b++) begin
        if (s_ff.buck[b] < buck_target_i[b]) begin
          nxt_s.buck[b] = s_ff.buck[b] + 7'h01;
        end else if (s_ff.buck[b] > buck_target_i[b]) begin
          nxt_s.buck[b] = s_ff.buck[b] - 7'h01;
        end
      end
    end else begin
      nxt_s.ramp_cnt = s_ff.ramp_cnt + bcc_pkg::RAMP_W'(1);
    end
  end

  // ==========================================================
  // State register; configuration returns to its defaults
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      s_ff <= '0;
      s_ff.cfg <= bcc_pkg::CFG_RST;
      s_ff.st <= ST_IDLE;
      s_ff.bat_present <= 1'b1;
      s_ff.phase <= bcc_pkg::PH_NONE;
      s_ff.vmv <= bcc_pkg::VT_4V20;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ==========================================================
  // Outputs straight from the state register
  assign phase_o = s_ff.phase;
  assign ilimit_ma_o = s_ff.ima;
  assign vtarget_mv_o = s_ff.vmv;
  assign batt_switch_open_o = s_ff.bsw_open;
  assign thermal_reg_o = s_ff.treg;
  assign bat_present_o = s_ff.bat_present;
  assign boost_pause_o = s_ff.bpause;
  assign power_off_o = s_ff.off;
  assign irq_o = s_ff.irq;
  // Open drain: the data level is always low, only the enable moves
  assign led_o = s_ff.irq.done & 1'b0;
  assign led_oe_o = s_ff.led_oe;
  assign rail_en_o = s_ff.rail_en;
  assign buck_code_o = s_ff.buck;
endmodule

// ===== core/bcc_pkg.sv
// Constants and carrier types for the battery charge controller
package bcc_pkg;

  // ==========================================================
  // Clock and time base
  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_NS = 10;
  // Blink and safety-timer tick rate
  localparam int TICK_HZ = 16;
  localparam int TICK_DIV = CLK_HZ / TICK_HZ;
  // Voltage ramp slopes, one step per period
  localparam int RAMP_FAST_NS = 15625;
  localparam int RAMP_SLOW_NS = 31250;
  localparam int RAMP_FAST_CYC = (RAMP_FAST_NS + CLK_NS - 1) / CLK_NS;
  localparam int RAMP_SLOW_CYC = (RAMP_SLOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int RAMP_W = 12;
  // Start-up sequence step length
  localparam int SEQ_STEP_US = 1000;
  localparam int SEQ_STEP_CYC = SEQ_STEP_US * 1000 / CLK_NS;
  localparam logic [2:0] SEQ_NEVER = 3'h7;
  localparam logic [2:0] SEQ_LAST = 3'h6;

  // ==========================================================
  // Safety timers, counted in ticks
  localparam int T1_BASE_MIN = 50;
  localparam int T1_STEP_MIN = 30;
  localparam int T2_BASE_HR = 12;
  localparam int T2_STEP_HR = 4;
  localparam int TICKS_PER_MIN = 60 * TICK_HZ;
  localparam int TMR_W = 22;

  // ==========================================================
  // Currents in mA and voltages in mV
  localparam logic [10:0] STEP_FINE_MA = 11'h019;
  localparam logic [10:0] KNEE_MA = 11'h0c8;
  localparam logic [10:0] STEP_COARSE_MA = 11'h064;
  localparam logic [10:0] FAST_MAX_MA = 11'h5dc;
  localparam logic [10:0] SAFE_MA = 11'h00a;
  localparam logic [4:0] FAST_KNEE_CODE = 5'h08;
  localparam logic [3:0] PRE_MAX_CODE = 4'h8;
  localparam logic [12:0] VT_4V00 = 13'h0fa0;
  localparam logic [12:0] VT_4V10 = 13'h1004;
  localparam logic [12:0] VT_4V20 = 13'h1068;
  localparam logic [12:0] VT_4V35 = 13'h10fe;
  localparam logic [12:0] VT_4V40 = 13'h1130;

  // ==========================================================
  // Charge-phase status codes
  localparam logic [2:0] PH_TRICKLE = 3'h0;
  localparam logic [2:0] PH_PRE = 3'h1;
  localparam logic [2:0] PH_CC = 3'h2;
  localparam logic [2:0] PH_CV = 3'h3;
  localparam logic [2:0] PH_DONE = 3'h4;
  localparam logic [2:0] PH_NONE = 3'h5;

  // Indicator styles and software indicator codes
  localparam logic [1:0] LED_STYLE_A = 2'h0;
  localparam logic [1:0] LED_STYLE_B = 2'h1;
  localparam logic [1:0] LED_STYLE_SW = 2'h2;
  localparam logic [1:0] LED_SW_1HZ = 2'h1;
  localparam logic [1:0] LED_SW_4HZ = 2'h2;
  localparam logic [1:0] LED_SW_LOW = 2'h3;

  // ==========================================================
  // Carrier types
  typedef struct packed {
    logic [3:0] prechg_code;
    logic [4:0] fast_code;
    logic [2:0] vtarget_sel;
    logic chg_en;
    logic term_en;
    logic timer_en;
    logic timer_dpm_en;
    logic [1:0] t1_sel;
    logic [1:0] t2_sel;
    logic bat_det_en;
    logic ts_chg_en;
    logic [1:0] led_mode;
    logic [1:0] led_sw;
    logic ramp_en;
    logic ramp_slow;
    logic [7:0] chg_hot;
    logic [7:0] chg_cold;
    logic [7:0] dis_hot;
    logic [7:0] dis_cold;
    logic [7:0] hot_hyst;
    logic [7:0] cold_hyst;
  } bcc_cfg_t;

  localparam bcc_cfg_t CFG_RST = '{prechg_code: 4'h5, fast_code: 5'h09,
    vtarget_sel: 3'h2, chg_en: 1'b1, term_en: 1'b1, timer_en: 1'b1,
    timer_dpm_en: 1'b1, t1_sel: 2'h0, t2_sel: 2'h0, bat_det_en: 1'b1,
    ts_chg_en: 1'b1, led_mode: 2'h0, led_sw: 2'h0, ramp_en: 1'b0,
    ramp_slow: 1'b0, chg_hot: 8'h1e, chg_cold: 8'ha5, dis_hot: 8'h16,
    dis_cold: 8'hc8, hot_hyst: 8'h04, cold_hyst: 8'h04};

  typedef struct packed {
    logic vbus_present;
    logic vbus_above_bat;
    logic src_good;
    logic die_reg;
    logic die_shut;
    logic bat_low;
    logic bat_at_target;
    logic bat_above_rechg;
    logic bat_ovp;
    logic in_ovp;
    logic below_term;
    logic in_dpm;
    logic bat_det;
    logic discharging;
    logic [7:0] ts_code;
  } bcc_sense_t;

  typedef struct packed {
    logic done;
    logic safe;
    logic die_shut;
    logic ts_chg;
    logic ts_work;
  } bcc_irq_t;

  // Timeout in ticks for a base plus a selected number of steps
  function automatic logic [TMR_W-1:0] bcc_tlim(input int base,
      input int step, input logic [1:0] sel, input int scale);
    return TMR_W'((base + step * int'(sel)) * scale);
  endfunction

endpackage

// ===== core/bcc_tick_gen.sv
// Free-running divider giving the tick and blink phase
`timescale 1ns/100ps
module bcc_tick_gen #(
  parameter int DIV = bcc_pkg::TICK_DIV
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // Time base
  output logic tick_o,
  output logic [3:0] phase_o
);
  localparam int CW = $clog2(DIV + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic [3:0] phase;
    logic tick;
  } bcc_tg_t;

  bcc_tg_t tg_ff;
  bcc_tg_t nxt_tg;

  // ==========================================================
  // One divider feeds both blink rates and the safety timers
  always_comb begin
    nxt_tg = tg_ff;
    nxt_tg.tick = 1'b0;
    if (tg_ff.cnt == CW'(DIV - 1)) begin
      nxt_tg.cnt = '0;
      nxt_tg.tick = 1'b1;
      nxt_tg.phase = tg_ff.phase + 4'h1;
    end else begin
      nxt_tg.cnt = tg_ff.cnt + CW'(1);
    end
  end

  // State register
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      tg_ff <= '0;
    end else begin
      tg_ff <= nxt_tg;
    end
  end

  assign tick_o = tg_ff.tick;
  assign phase_o = tg_ff.phase;
endmodule

// ===== verification/bcc_core_assertions.sv
// Port assertions for the charge controller core
`timescale 1ns/100ps
module bcc_core_assertions #(
  parameter int N_RAIL = 15
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // Inputs watched
  input wire bcc_pkg::bcc_sense_t sense_i,
  input wire logic seq_start_i,
  input wire logic [N_RAIL-1:0][2:0] seq_code_i,
  // Outputs watched
  input wire logic [2:0] phase_o,
  input wire logic [10:0] ilimit_ma_o,
  input wire logic [12:0] vtarget_mv_o,
  input wire logic batt_switch_open_o,
  input wire logic power_off_o,
  input wire bcc_pkg::bcc_irq_t irq_o,
  input wire logic [N_RAIL-1:0] rail_en_o
);
  // ==========
  // One domain, so clock and reset are given once
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  // Power-off is final until reset, whatever the die does
  off_latch_a: assert property (
    power_off_o |=> power_off_o) else $error("power off dropped");
  die_off_a: assert property (
    sense_i.die_shut |-> ##[1:3] power_off_o) else $error("no power off");
  die_irq_a: assert property (
    sense_i.die_shut && !power_off_o |=> irq_o.die_shut)
    else $error("no shutdown event");
  vt_reset_a: assert property (
    $fell(srst_i) |-> vtarget_mv_o == bcc_pkg::VT_4V20)
    else $error("target not 4200");
  done_open_a: assert property (
    phase_o == bcc_pkg::PH_DONE |-> batt_switch_open_o)
    else $error("switch shut in done");
  done_pulse_a: assert property (
    irq_o.done |=> !irq_o.done) else $error("done event too long");
  safe_curr_a: assert property (
    phase_o == bcc_pkg::PH_TRICKLE |-> ilimit_ma_o == bcc_pkg::SAFE_MA)
    else $error("safe current wrong");
  no_input_a: assert property (
    !sense_i.vbus_present [*3] |-> !(phase_o inside {[3'h1:3'h3]}))
    else $error("charging without input");
  // Rails 0 to 2 carry fixed codes in the bench
  never_rail_a: assert property (
    seq_code_i[0] == bcc_pkg::SEQ_NEVER |-> !rail_en_o[0])
    else $error("code 7 rail on");
  first_rail_a: assert property (
    seq_start_i && seq_code_i[1] == 3'h0 |-> ##[1:2] rail_en_o[1])
    else $error("code 0 rail late");
  later_rail_a: assert property (
    seq_start_i && seq_code_i[2] == 3'h2 |-> ##2 !rail_en_o[2] [*8])
    else $error("code 2 rail early");
endmodule

bind bcc_core bcc_core_assertions #(.N_RAIL(N_RAIL)) u_bcc_chk (
  .clk_sys_i, .srst_i, .sense_i, .seq_start_i, .seq_code_i, .phase_o,
  .ilimit_ma_o, .vtarget_mv_o, .batt_switch_open_o, .power_off_o, .irq_o,
  .rail_en_o);

// ===== verification/bcc_host_model.sv
// Host-side model that loads configuration images
`timescale 1ns/100ps
module bcc_host_model (
  // Clock
  input wire logic clk_sys_i,
  // Configuration port
  output logic cfg_wr_o,
  output bcc_pkg::bcc_cfg_t cfg_o
);
  // Idle on the reset image so nothing unknown reaches the core
  initial begin
    cfg_wr_o = 1'b0;
    cfg_o = bcc_pkg::CFG_RST;
  end
  // Image and strobe held over exactly one taking edge
  task automatic wr(input bcc_pkg::bcc_cfg_t c);
    cfg_o = c;
    cfg_wr_o = 1'b1;
    @(posedge clk_sys_i);
    #1 cfg_wr_o = 1'b0;
  endtask
endmodule

// ===== verification/battery_charge_controller_test.sv
// Self-checking bench for the charge controller core
`timescale 1ns/100ps
module battery_charge_controller_test;
  // ==========
  // Bench signals
  logic clk, srst, start, wr, sw, poff, oe, bp, treg, bpo;
  logic [14:0][2:0] code;
  logic [1:0][6:0] tgt, buck;
  bcc_pkg::bcc_sense_t s;
  bcc_pkg::bcc_cfg_t c, cfg;
  logic [2:0] ph;
  logic [10:0] ilim;
  logic [12:0] vt;
  logic [14:0] rail, e;
  int err_count, tests_run, n, k, t1;
  int seed = 32'hd474a8cf;
  int vtq[$] = '{4000, 4100, 4200, 4350, 4400, 4400, 4400, 4400};
  // Short tick and step so the timer fits the run
  bcc_core #(.TICK_DIV(1), .SEQ_STEP_CYC(8)) u_bcc_core (.clk_sys_i(clk),
    .srst_i(srst), .cfg_wr_i(wr), .cfg_i(cfg), .sense_i(s),
    .seq_start_i(start), .seq_code_i(code), .buck_target_i(tgt),
    .phase_o(ph), .ilimit_ma_o(ilim), .vtarget_mv_o(vt),
    .batt_switch_open_o(sw), .thermal_reg_o(treg), .bat_present_o(bp),
    .boost_pause_o(bpo), .power_off_o(poff), .irq_o(), .led_o(),
    .led_oe_o(oe), .rail_en_o(rail), .buck_code_o(buck));
  bcc_host_model u_bcc_host_model (.clk_sys_i(clk), .cfg_wr_o(wr),
    .cfg_o(cfg));
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Step edges, landing just past the last one
  task automatic cyc(input int m);
    repeat (m) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("Error t=%0t seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Bounded wait for a phase; n keeps the cycles spent
  task automatic wph(input logic [2:0] p, input int lim);
    for (n = 0; n < lim && ph !== p; n++) cyc(1);
    if (ph !== p) begin
      err_count++;
      report_and_stop();
    end
  endtask
  // Fast current model: fine steps to the knee, then coarse to the top
  function automatic int fast_ma(input int i);
    if (i <= 8) return i * 25;
    return (i > 21) ? 1500 : 200 + (i - 8) * 100;
  endfunction
  // ==========
  // Main sequence
  initial begin
    {srst, start, s, tgt, code} = {1'b1, 1'b0, 22'h0, 14'h0, 45'h0};
    t1 = bcc_pkg::T1_BASE_MIN * bcc_pkg::TICKS_PER_MIN;
    cyc(6);
    srst = 1'b0;
    chk(16'(ph), 16'(bcc_pkg::PH_NONE));
    chk(16'(bp), 16'h1);
    c = bcc_pkg::CFG_RST;
    for (k = 0; k < 8; k++) begin
      c.vtarget_sel = k[2:0];
      u_bcc_host_model.wr(c);
      cyc(2);
      chk(16'(vt), 16'(vtq[k]));
    end
    // Deep battery with every charge condition met
    s = '{vbus_present: 1'b1, vbus_above_bat: 1'b1, src_good: 1'b1,
      bat_low: 1'b1, bat_det: 1'b1, ts_code: 8'h60, default: 1'b0};
    tgt = 14'($random(seed));
    wph(bcc_pkg::PH_PRE, 8);
    for (k = 0; k < 16; k++) begin
      c.prechg_code = k[3:0];
      u_bcc_host_model.wr(c);
      cyc(2);
      chk(16'(ilim), 16'((k > 8 ? 8 : k) * 25));
    end
    s.bat_low = 1'b0;
    wph(bcc_pkg::PH_CC, 8);
    for (k = 0; k < 32; k++) begin
      c.fast_code = k[4:0];
      u_bcc_host_model.wr(c);
      cyc(2);
      chk(16'(ilim), 16'(fast_ma(k)));
    end
    s.bat_at_target = 1'b1;
    wph(bcc_pkg::PH_CV, 8);
    // Regulation holds off termination
    {s.bat_above_rechg, s.below_term, s.in_dpm, s.die_reg} = 4'hf;
    cyc(6);
    chk(16'(ph), 16'(bcc_pkg::PH_CV));
    chk(16'(treg), 16'h1);
    {s.in_dpm, s.die_reg} = 2'h0;
    wph(bcc_pkg::PH_DONE, 8);
    chk(16'(sw), 16'h1);
    // Sagging battery restarts, then the first timer expires
    {s.bat_above_rechg, s.below_term, s.bat_at_target, s.bat_low} = 4'h1;
    wph(bcc_pkg::PH_PRE, 8);
    wph(bcc_pkg::PH_TRICKLE, 60000);
    chk(16'(n > t1 - 10 && n < t1 + 10), 16'h1);
    u_bcc_host_model.wr(c);
    wph(bcc_pkg::PH_PRE, 8);
    cyc(1);
    chk(16'(oe), 16'h1);
    c.chg_en = 1'b0;
    u_bcc_host_model.wr(c);
    wph(bcc_pkg::PH_NONE, 8);
    cyc(1);
    chk(16'(oe), 16'h0);
    // Start-up order with random codes, first three fixed
    for (k = 0; k < 15; k++) code[k] = 3'($random(seed));
    code[2:0] = {3'h2, 3'h0, 3'h7};
    start = 1'b1;
    cyc(1);
    start = 1'b0;
    cyc(3);
    for (k = 0; k < 7; k++) begin
      for (n = 0; n < 15; n++) e[n] = (code[n] <= k[2:0]);
      chk(16'(rail), 16'(e));
      cyc(8);
    end
    // Ramp moves one step toward a far target
    c.ramp_en = 1'b1;
    u_bcc_host_model.wr(c);
    t1 = buck[0];
    tgt[0] = 7'(t1 ^ 64);
    cyc(1600);
    chk(16'(buck[0]), 16'(t1 < 64 ? t1 + 1 : t1 - 1));
    // Hot thermistor while discharging pauses the boost
    s.discharging = 1'b1;
    s.ts_code = 8'h00;
    cyc(2);
    chk(16'(bpo), 16'h1);
    s.ts_code = 8'h60;
    cyc(2);
    chk(16'(bpo), 16'h0);
    // Overheat powers off and stays off once cooled
    s.die_shut = 1'b1;
    cyc(4);
    chk(16'(poff), 16'h1);
    s.die_shut = 1'b0;
    cyc(8);
    chk(16'(poff), 16'h1);
    report_and_stop();
  end
endmodule
